// ===== core/rpc_map.vh
`ifndef RPC_MAP_VH
`define RPC_MAP_VH

// ****************************************
// register byte addresses
// ****************************************
`define RPC_ADDR_CORE_CTRL 8'h54
`define RPC_ADDR_RESET_FLAGS 8'h58
`define RPC_ADDR_CLOCK_GATE 8'h64

// ****************************************
// core control fields
// ****************************************
`define RPC_CC_SLEEP_OFF 6
`define RPC_CC_SLEEP_UNLOCK 5
`define RPC_CC_PULLUP_OFF 4
`define RPC_CC_VEC_SELECT 1
`define RPC_CC_VEC_CHANGE 0
`define RPC_CC_RESET 8'h00

// ****************************************
// peripheral clock gate fields
// ****************************************
`define RPC_PG_TWO_WIRE 7
`define RPC_PG_TIMER_TWO 6
`define RPC_PG_TIMER_ZERO 5
`define RPC_PG_RESERVED 4
`define RPC_PG_TIMER_ONE 3
`define RPC_PG_SERIAL_PERIPH 2
`define RPC_PG_UART_ZERO 1
`define RPC_PG_CONVERTER 0
`define RPC_PG_RESET 8'h00
`define RPC_PG_WRITE_MASK 8'hef

// ****************************************
// reset flag fields
// ****************************************
`define RPC_RF_WATCHDOG 3
`define RPC_RF_BROWNOUT 2
`define RPC_RF_EXTERNAL 1
`define RPC_RF_POWERON 0
`define RPC_RF_RESET 4'h0

// ****************************************
// timing
// ****************************************
`define RPC_CLK_MHZ 250
`define RPC_UNLOCK_WINDOW 3'h4
`define RPC_SLEEP_OFF_ACTIVE 3'h3
`define RPC_SLEEP_OFF_CLEAR 3'h6
`define RPC_TOUT_SUT0_US 0
`define RPC_TOUT_SUT1_US 4100
`define RPC_TOUT_SUT2_US 65000
`define RPC_TOUT_SUT3_US 65000
`define RPC_XTAL_START_CYCLES 16384
`define RPC_BROWNOUT_FUSE_OFF 3'h7

`endif

// ===== core/rpc_delay.v
`timescale 1ns/1ps
`include "rpc_map.vh"

// ****************************************
// reset stretch counter
// ****************************************
module rpc_delay #(
   parameter CW = 24
) (
   input wire clk_sys,
   input wire hold,
   input wire [CW-1:0] target,
   output wire done
);

   reg [CW-1:0] cnt_r;
   reg done_r;

   assign done = done_r;

   // any active source restarts the count at once, no clock needed
   always @(posedge clk_sys or posedge hold) begin
      if (hold) begin
         cnt_r <= {CW{1'b0}};
         done_r <= 1'b0;
      end else if (!done_r) begin
         if (cnt_r >= target) begin
            done_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule

// ===== core/rpc_top.v
`timescale 1ns/1ps
`include "rpc_map.vh"

module rpc_top #(
   parameter [23:0] TOUT_SUT0 = `RPC_TOUT_SUT0_US * `RPC_CLK_MHZ,
   parameter [23:0] TOUT_SUT1 = `RPC_TOUT_SUT1_US * `RPC_CLK_MHZ,
   parameter [23:0] TOUT_SUT2 = `RPC_TOUT_SUT2_US * `RPC_CLK_MHZ,
   parameter [23:0] TOUT_SUT3 = `RPC_TOUT_SUT3_US * `RPC_CLK_MHZ,
   parameter [23:0] XTAL_START = `RPC_XTAL_START_CYCLES
) (
   input wire clk_sys,
   input wire rst,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output wire [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire supply_low,
   input wire ext_rst_n,
   input wire wdt_timeout,
   input wire wdt_reset_mode,
   input wire brownout_low,
   input wire reset_pin_disable_fuse,
   input wire [2:0] brownout_level_fuse,
   input wire [1:0] startup_time_fuse,
   input wire [3:0] clock_select_fuse,
   input wire sleep_exec,
   input wire sleep_wake,
   input wire timer_two_async_select,
   output wire cpu_reset,
   output wire io_port_reset,
   output wire [7:0] periph_stop,
   output wire acmp_mux_block,
   output wire brownout_sleep_off_active,
   output wire brownout_off_in_sleep
);

   // ****************************************
   // declarations
   // ****************************************
   reg wait_r;
   reg [31:0] rdata_r;
   reg [31:0] rdata_nxt;
   reg [7:0] gate_r;
   reg [2:0] cc_plain_r;
   reg unlock_r;
   reg [2:0] win_r;
   reg sleep_off_r;
   reg [2:0] so_cnt_r;
   reg so_active_r;
   reg off_in_sleep_r;
   reg [3:0] flags_r;
   reg wdt_prev_r;
   reg wdt_pulse_r;
   reg pin_dis_r;
   reg brownout_en_r;
   reg [23:0] tout_nxt;
   reg cpu_reset_r;
   reg io_reset_r;
   reg [7:0] stop_r;
   reg acmp_block_r;
   wire req;
   wire take;
   wire wr_take;
   wire wr_cc;
   wire wr_gate;
   wire wr_flags;
   wire arm;
   wire src_por;
   wire src_ext;
   wire src_bo;
   wire src_any;
   wire hold;
   wire delay_done;

   // ****************************************
   // register bus slave
   // ****************************************
   assign req = avs_read | avs_write;
   assign take = req & ~wait_r;
   assign wr_take = take & avs_write;
   assign wr_cc = wr_take & ({avs_address[7:2], 2'b00} == `RPC_ADDR_CORE_CTRL);
   assign wr_gate = wr_take & ({avs_address[7:2], 2'b00} == `RPC_ADDR_CLOCK_GATE);
   assign wr_flags = wr_take & ({avs_address[7:2], 2'b00} == `RPC_ADDR_RESET_FLAGS);
   assign avs_waitrequest = wait_r;
   assign avs_readdata = rdata_r;

   // one wait cycle per access; read data is latched in that wait cycle
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~(req & wait_r);
      end
   end

   // read mux; unmapped addresses read as zero
   always @* begin
      rdata_nxt = 32'h0000_0000;
      case ({avs_address[7:2], 2'b00})
         `RPC_ADDR_CORE_CTRL: begin
            rdata_nxt[`RPC_CC_SLEEP_OFF] = sleep_off_r;
            rdata_nxt[`RPC_CC_SLEEP_UNLOCK] = unlock_r;
            rdata_nxt[`RPC_CC_PULLUP_OFF] = cc_plain_r[2];
            rdata_nxt[`RPC_CC_VEC_SELECT] = cc_plain_r[1];
            rdata_nxt[`RPC_CC_VEC_CHANGE] = cc_plain_r[0];
         end
         `RPC_ADDR_CLOCK_GATE: begin
            rdata_nxt[7:0] = gate_r & `RPC_PG_WRITE_MASK;
         end
         `RPC_ADDR_RESET_FLAGS: begin
            rdata_nxt[3:0] = flags_r;
         end
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read && wait_r) begin
         rdata_r <= rdata_nxt;
      end
   end

   // ****************************************
   // plain control registers
   // ****************************************
   // internal reset returns both to their initial values
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gate_r <= `RPC_PG_RESET;
         cc_plain_r <= 3'h0;
      end else if (cpu_reset_r) begin
         gate_r <= `RPC_PG_RESET;
         cc_plain_r <= 3'h0;
      end else begin
         if (wr_gate) begin
            gate_r <= avs_writedata[7:0] & `RPC_PG_WRITE_MASK;
         end
         if (wr_cc) begin
            cc_plain_r <= {avs_writedata[`RPC_CC_PULLUP_OFF],
                           avs_writedata[`RPC_CC_VEC_SELECT],
                           avs_writedata[`RPC_CC_VEC_CHANGE]};
         end
      end
   end

   // ****************************************
   // brown-out sleep-off timed sequence
   // ****************************************
   // a second write can land two cycles after the first at the earliest,
   // so the four-cycle window always fits one bus access
   assign arm = wr_cc & unlock_r & avs_writedata[`RPC_CC_SLEEP_OFF]
                & ~avs_writedata[`RPC_CC_SLEEP_UNLOCK];

   // unlock window opens on a write with both bits set
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         unlock_r <= 1'b0;
         win_r <= 3'h0;
      end else if (cpu_reset_r || arm) begin
         unlock_r <= 1'b0;
         win_r <= 3'h0;
      end else if (wr_cc && avs_writedata[`RPC_CC_SLEEP_OFF]
                   && avs_writedata[`RPC_CC_SLEEP_UNLOCK]) begin
         unlock_r <= 1'b1;
         win_r <= `RPC_UNLOCK_WINDOW;
      end else if (win_r != 3'h0) begin
         win_r <= win_r - 3'h1;
         if (win_r == 3'h1) begin
            unlock_r <= 1'b0;
         end
      end
   end

   // a late or unlocked write never reaches the bit: only arm sets it
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sleep_off_r <= 1'b0;
         so_cnt_r <= 3'h0;
         so_active_r <= 1'b0;
      end else if (cpu_reset_r) begin
         sleep_off_r <= 1'b0;
         so_cnt_r <= 3'h0;
         so_active_r <= 1'b0;
      end else if (arm && !sleep_off_r) begin
         sleep_off_r <= 1'b1;
         so_cnt_r <= 3'h0;
      end else if (sleep_off_r) begin
         so_cnt_r <= so_cnt_r + 3'h1;
         if (so_cnt_r == `RPC_SLEEP_OFF_ACTIVE - 3'h1) begin
            so_active_r <= 1'b1;
         end
         if (so_cnt_r == `RPC_SLEEP_OFF_CLEAR - 3'h1) begin
            sleep_off_r <= 1'b0;
            so_active_r <= 1'b0;
         end
      end
   end

   // detector stays off until the core wakes up again
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         off_in_sleep_r <= 1'b0;
      end else if (cpu_reset_r || sleep_wake) begin
         off_in_sleep_r <= 1'b0;
      end else if (sleep_exec && so_active_r) begin
         off_in_sleep_r <= 1'b1;
      end
   end

   // ****************************************
   // fuse sampling
   // ****************************************
   // clock select bit 3 picks a crystal, which adds an oscillator start-up
   always @* begin
      case (startup_time_fuse)
         2'h0: tout_nxt = TOUT_SUT0;
         2'h1: tout_nxt = TOUT_SUT1;
         2'h2: tout_nxt = TOUT_SUT2;
         default: tout_nxt = TOUT_SUT3;
      endcase
      if (clock_select_fuse[3]) begin
         tout_nxt = tout_nxt + XTAL_START;
      end
   end

   // fuses are static: they are only followed while reset is held
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_dis_r <= 1'b0;
         brownout_en_r <= 1'b0;
      end else if (cpu_reset_r) begin
         pin_dis_r <= reset_pin_disable_fuse;
         brownout_en_r <= (brownout_level_fuse != `RPC_BROWNOUT_FUSE_OFF);
      end
   end

   // ****************************************
   // reset sources
   // ****************************************
   // supply and pin are combinational so reset works with no clock
   assign src_por = supply_low;
   assign src_ext = ~ext_rst_n & ~pin_dis_r;
   assign src_bo = brownout_low & brownout_en_r & ~off_in_sleep_r;
   assign src_any = src_por | src_ext | src_bo | wdt_pulse_r;
   assign hold = rst | src_any;

   // watchdog time-out edge becomes a single-cycle pulse; this flop is
   // cleared only by rst, since clearing it with hold would self-loop
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wdt_prev_r <= 1'b0;
         wdt_pulse_r <= 1'b0;
      end else begin
         wdt_prev_r <= wdt_timeout;
         wdt_pulse_r <= wdt_timeout & ~wdt_prev_r & wdt_reset_mode;
      end
   end

   rpc_delay #(
      .CW(24)
   ) u_delay (
      .clk_sys(clk_sys),
      .hold(hold),
      .target(tout_nxt), // live fuses: a copy cleared by rst would cut the first stretch to nothing
      .done(delay_done)
   );

   // internal and port resets set at once, release after the time-out
   always @(posedge clk_sys or posedge hold) begin
      if (hold) begin
         cpu_reset_r <= 1'b1;
         io_reset_r <= 1'b1;
      end else begin
         cpu_reset_r <= ~delay_done;
         io_reset_r <= ~delay_done;
      end
   end

   assign cpu_reset = cpu_reset_r;
   assign io_port_reset = io_reset_r;

   // ****************************************
   // reset flags
   // ****************************************
   // sources set flags over zero writes; power-on wipes the others
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flags_r <= `RPC_RF_RESET;
      end else if (src_por) begin
         flags_r <= 4'h1 << `RPC_RF_POWERON;
      end else begin
         if (wr_flags) begin
            flags_r <= flags_r & avs_writedata[3:0];
         end
         if (src_ext) begin
            flags_r[`RPC_RF_EXTERNAL] <= 1'b1;
         end
         if (src_bo) begin
            flags_r[`RPC_RF_BROWNOUT] <= 1'b1;
         end
         if (wdt_pulse_r) begin
            flags_r[`RPC_RF_WATCHDOG] <= 1'b1;
         end
      end
   end

   // ****************************************
   // peripheral clock stops
   // ****************************************
   // a stopped peripheral keeps its state, so clearing the bit resumes it
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_stop
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               stop_r[g] <= 1'b0;
            end else if (g == `RPC_PG_TIMER_TWO) begin
               stop_r[g] <= gate_r[g] & ~timer_two_async_select;
            end else begin
               stop_r[g] <= gate_r[g];
            end
         end
      end
   endgenerate

   // comparator loses the converter mux while the converter is shut
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acmp_block_r <= 1'b0;
      end else begin
         acmp_block_r <= gate_r[`RPC_PG_CONVERTER];
      end
   end

   assign periph_stop = stop_r;
   assign acmp_mux_block = acmp_block_r;
   assign brownout_sleep_off_active = so_active_r;
   assign brownout_off_in_sleep = off_in_sleep_r;

endmodule

// ===== verification/rpc_top_asserts.sv
`timescale 1ns/1ps
// ****************************************
// port-level checker for the reset and power block
// ****************************************
module rpc_asserts (
   input wire clk_sys,
   input wire rst,
   input wire avs_waitrequest,
   input wire supply_low,
   input wire ext_rst_n,
   input wire wdt_timeout,
   input wire wdt_reset_mode,
   input wire reset_pin_disable_fuse,
   input wire sleep_exec,
   input wire timer_two_async_select,
   input wire cpu_reset,
   input wire io_port_reset,
   input wire [7:0] periph_stop,
   input wire acmp_mux_block,
   input wire brownout_sleep_off_active,
   input wire brownout_off_in_sleep
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_gate_reserved: assert property (periph_stop[4] == 1'b0)
      else $error("reserved gate bit drives a stop");
   chk_timer_two_async: assert property (timer_two_async_select |=> !periph_stop[6])
      else $error("timer two stopped in async mode");
   chk_mux_block: assert property (acmp_mux_block == periph_stop[0])
      else $error("comparator mux block differs from converter stop");
   chk_poweron_ports: assert property (supply_low |-> io_port_reset && cpu_reset)
      else $error("supply low without reset");
   chk_pin_reset: assert property (!ext_rst_n && !reset_pin_disable_fuse |-> cpu_reset)
      else $error("pin low without reset");
   chk_wdt_reset: assert property ($rose(wdt_timeout) && wdt_reset_mode |-> ##[0:2] cpu_reset)
      else $error("watchdog expiry gave no reset");
   chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   // sleep-off stays in effect exactly three cycles, then drops by itself
   chk_sleep_off_life: assert property ($rose(brownout_sleep_off_active) |->
      brownout_sleep_off_active[*3] ##1 !brownout_sleep_off_active)
      else $error("sleep-off active span wrong");
   chk_off_in_sleep: assert property ($rose(brownout_off_in_sleep) |->
      $past(sleep_exec) && $past(brownout_sleep_off_active))
      else $error("detector off without armed sleep");
   chk_release_stretch: assert property ($fell(cpu_reset) |->
      !supply_low && $past(!supply_low) && $past(!supply_low, 2))
      else $error("reset released without stretch");

   cov_wdt: cover property ($rose(wdt_timeout) && wdt_reset_mode);
   cov_sleep: cover property ($rose(brownout_off_in_sleep));
   cov_release: cover property ($fell(cpu_reset));
endmodule

bind rpc_top rpc_asserts i_rpc_asserts (.clk_sys, .rst, .avs_waitrequest, .supply_low, .ext_rst_n,
   .wdt_timeout, .wdt_reset_mode, .reset_pin_disable_fuse, .sleep_exec, .timer_two_async_select,
   .cpu_reset, .io_port_reset, .periph_stop, .acmp_mux_block, .brownout_sleep_off_active,
   .brownout_off_in_sleep);

// ===== verification/test_rpc_top.sv
`timescale 1ns/1ps
`include "rpc_map.vh"
module test_rpc_top;
   logic clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0, supply_low = 0, ext_rst_n = 1;
   logic wdt_timeout = 0, wdt_reset_mode = 0, brownout_low = 0, reset_pin_disable_fuse = 0;
   logic sleep_exec = 0, sleep_wake = 0, timer_two_async_select = 0;
   logic [7:0] avs_address = 8'h00, q;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [2:0] brownout_level_fuse = 3'h7;
   logic [1:0] startup_time_fuse = 2'h0;
   logic [3:0] clock_select_fuse = 4'h0;
   logic avs_waitrequest, cpu_reset, io_port_reset, acmp_mux_block;
   logic brownout_sleep_off_active, brownout_off_in_sleep;
   logic [7:0] periph_stop;
   int n_errors = 0, checks = 0, cyc = 0;

   // short counts keep the run brief: sut0 10, sut1 20, crystal start 8
   rpc_top #(.TOUT_SUT0(24'h00000a), .TOUT_SUT1(24'h000014), .TOUT_SUT2(24'h00001e),
      .TOUT_SUT3(24'h00001e), .XTAL_START(24'h000008)) i_rpc_top (.clk_sys, .rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .supply_low, .ext_rst_n,
      .wdt_timeout, .wdt_reset_mode, .brownout_low, .reset_pin_disable_fuse, .brownout_level_fuse,
      .startup_time_fuse, .clock_select_fuse, .sleep_exec, .sleep_wake, .timer_two_async_select,
      .cpu_reset, .io_port_reset, .periph_stop, .acmp_mux_block, .brownout_sleep_off_active,
      .brownout_off_in_sleep);

   // ****************************************
   // clock, timeout and reporting
   // ****************************************
   always #2 clk_sys = ~clk_sys;

   // a hung wait ends here instead of running forever
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         complete_run();
      end
   end

   task complete_run();
      if (n_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task chk(input [31:0] seen, input [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // one access; the leading edge keeps two accesses from driving in one step
   task bus(input logic w, input [7:0] a, input [7:0] d, output [7:0] r);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      r = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // counts edges until the internal reset drops; e of zero skips the length check
   task rel(input int e);
      int n;
      n = 0;
      while (cpu_reset !== 1'b0 && n < 200) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (e != 0) chk(n, e, "stretch length");
      chk(cpu_reset, 1'b0, "reset not released");
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task t_gate();
      bus(1, `RPC_ADDR_CLOCK_GATE, 8'hff, q);
      bus(0, `RPC_ADDR_CLOCK_GATE, 8'h00, q);
      chk(q, 8'hef, "gate readback");
      #1 chk(periph_stop, 8'hef, "stop lines");
      chk(acmp_mux_block, 1'b1, "mux block");
      @(posedge clk_sys);
      timer_two_async_select <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk(periph_stop[6], 1'b0, "async timer two");
      bus(1, `RPC_ADDR_CLOCK_GATE, 8'h00, q);
      bus(0, 8'h10, 8'h00, q);
      chk(q, 8'h00, "unmapped read");
      chk(periph_stop, 8'h00, "stop lines cleared");
   endtask

   task t_sleep();
      bus(1, `RPC_ADDR_CORE_CTRL, 8'h60, q);
      bus(1, `RPC_ADDR_CORE_CTRL, 8'h40, q);
      bus(0, `RPC_ADDR_CORE_CTRL, 8'h00, q);
      chk(q[6], 1'b1, "sleep-off bit armed");
      sleep_exec <= 1'b1;
      #1 chk(brownout_sleep_off_active, 1'b1, "sleep-off active");
      @(posedge clk_sys);
      sleep_exec <= 1'b0;
      #1 chk(brownout_off_in_sleep, 1'b1, "detector off");
      repeat (2) @(posedge clk_sys);
      #1 chk(brownout_sleep_off_active, 1'b0, "sleep-off self clear");
      @(posedge clk_sys);
      sleep_wake <= 1'b1;
      @(posedge clk_sys);
      sleep_wake <= 1'b0;
      bus(1, `RPC_ADDR_CORE_CTRL, 8'h60, q);
      repeat (6) @(posedge clk_sys);
      bus(1, `RPC_ADDR_CORE_CTRL, 8'h40, q);
      sleep_exec <= 1'b1;
      @(posedge clk_sys);
      sleep_exec <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 chk(brownout_sleep_off_active, 1'b0, "late write armed");
      chk(brownout_off_in_sleep, 1'b0, "detector off unarmed");
      bus(0, `RPC_ADDR_CORE_CTRL, 8'h00, q);
      chk(q[6], 1'b0, "sleep-off bit set");
   endtask

   // pin reset with new fuses, then clearing the flags
   task t_ext();
      @(posedge clk_sys);
      startup_time_fuse <= 2'h1;
      clock_select_fuse <= 4'h8;
      brownout_level_fuse <= 3'h0;
      ext_rst_n <= 1'b0;
      #1 chk(io_port_reset, 1'b1, "pin port reset");
      repeat (3) @(posedge clk_sys);
      ext_rst_n <= 1'b1;
      rel(30);
      bus(0, `RPC_ADDR_RESET_FLAGS, 8'h00, q);
      chk(q, 8'h02, "external flag");
      bus(1, `RPC_ADDR_RESET_FLAGS, 8'h00, q);
      bus(0, `RPC_ADDR_RESET_FLAGS, 8'h00, q);
      chk(q, 8'h00, "flags cleared");
   endtask

   task t_wdt();
      @(posedge clk_sys);
      wdt_timeout <= 1'b1;
      @(posedge clk_sys);
      wdt_timeout <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 chk(cpu_reset, 1'b0, "watchdog without mode");
      @(posedge clk_sys);
      wdt_reset_mode <= 1'b1;
      wdt_timeout <= 1'b1;
      reset_pin_disable_fuse <= 1'b1;
      @(posedge clk_sys);
      wdt_timeout <= 1'b0;
      #1 chk(cpu_reset, 1'b1, "watchdog reset");
      rel(0);
      bus(0, `RPC_ADDR_RESET_FLAGS, 8'h00, q);
      chk(q, 8'h08, "watchdog flag");
      @(posedge clk_sys);
      ext_rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 chk(cpu_reset, 1'b0, "disabled pin reset");
      @(posedge clk_sys);
      ext_rst_n <= 1'b1;
   endtask

   task t_pwr();
      bus(1, `RPC_ADDR_CLOCK_GATE, 8'h01, q);
      @(posedge clk_sys);
      supply_low <= 1'b1;
      #1 chk(io_port_reset, 1'b1, "power-on port reset");
      repeat (3) @(posedge clk_sys);
      supply_low <= 1'b0;
      rel(30);
      bus(0, `RPC_ADDR_RESET_FLAGS, 8'h00, q);
      chk(q, 8'h01, "power-on flag");
      bus(0, `RPC_ADDR_CLOCK_GATE, 8'h00, q);
      chk(q, 8'h00, "gate reset value");
      @(posedge clk_sys);
      brownout_low <= 1'b1;
      #1 chk(cpu_reset, 1'b1, "brown-out reset");
      repeat (3) @(posedge clk_sys);
      brownout_low <= 1'b0;
      rel(30);
      bus(0, `RPC_ADDR_RESET_FLAGS, 8'h00, q);
      chk(q, 8'h05, "brown-out flag");
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      rel(12);
      t_gate();
      t_sleep();
      t_ext();
      t_wdt();
      t_pwr();
      complete_run();
   end
endmodule
